// ===== rtl/atp_pkg.sv
// shared constants and types of the accelerometer two-wire target port
package atp_pkg;
  localparam logic [6:0] ATP_TARGET_ADDR = 7'h0f;  // fixed target address, 0001111
  localparam int         ATP_BYTE_BITS   = 8;      // bits per byte on the bus
  localparam logic       ATP_DIR_READ    = 1'h1;   // lowest address bit, read from target
  localparam logic [7:0] ATP_PTR_RESET   = 8'h00;  // register pointer after reset
  localparam int         ATP_FIFO_DEPTH  = 4;      // write path buffer words
  localparam int         ATP_FIFO_WIDTH  = 16;     // pointer plus data byte
  localparam int         ATP_SYNC_STAGES = 2;      // pin synchroniser depth

  // byte-level sequencer states
  typedef enum logic [3:0] {
    ATP_IDLE,    // bus free or busy with nobody for us
    ATP_ADDR,    // shifting in the address byte
    ATP_PTR,     // shifting in the register pointer
    ATP_WDATA,   // shifting in write data
    ATP_PUSH,    // handing write byte to the buffer, may stretch
    ATP_ACK,     // driving acknowledge low for one bit
    ATP_LOAD,    // waiting for read data, may stretch
    ATP_TX,      // shifting out read data
    ATP_RACK,    // listening to controller acknowledge
    ATP_IGNORE   // not addressed or read ended, wait for start or stop
  } atp_state_t;
endpackage

// ===== rtl/atp_fifo.sv
// shift-register FIFO between the serial port and the register file writer
`timescale 1ns/1ns
`default_nettype none
module atp_fifo #(
  parameter int WIDTH = 16,  // word width
  parameter int DEPTH = 4    // number of words
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  // refuse shapes the shifting scheme cannot serve
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
    $error("atp_fifo needs DEPTH >= 2 and WIDTH >= 1");
  end

  logic [WIDTH-1:0] mem      [DEPTH];  // slot 0 is the head
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [DEPTH-1:0] vld;               // slot occupied flags, packed from 0
  logic [DEPTH-1:0] next_vld;
  logic             push;
  logic             pop;

  // head comes straight from slot 0 flops so the consumer sees registered data
  assign out_valid = vld[0];
  assign out_data  = mem[0];
  // full refuses a push even if a pop happens too; costs one cycle, keeps ready flop-based
  assign in_ready  = ~vld[DEPTH-1];
  assign push      = in_valid & in_ready;
  assign pop       = vld[0] & out_ready;

  // shift down on pop, then drop the new word into the first free slot
  always_comb begin
    logic placed;
    placed   = 1'b0;
    next_vld = vld;
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_mem[i] = mem[i+1];
        next_vld[i] = vld[i+1];
      end
      next_vld[DEPTH-1] = 1'b0;
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (push && !placed && !next_vld[i]) begin
        next_mem[i] = in_data;
        next_vld[i] = 1'b1;
        placed      = 1'b1;
      end
    end
  end

  // registers only; enable low freezes the buffer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vld <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (en) begin
      vld <= next_vld;
      mem <= next_mem;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/atp_i2c_target.sv
// two-wire target port: address match, register pointer, burst write and read
// Contract
// R1: device is target only, never drives clock pulses
// R2: controller starts, clocks and ends every transfer
// R3: bytes are eight bits, msb first, unlimited count
// R4: bus idle when clock and data high
// R5: start is data fall with clock high
// R6: first byte: seven address bits, then direction
// R7: respond only when address equals fixed address
// R8: receiver holds data low through ack high
// R9: stop is data rise with clock high
// R10: write: address, pointer, data, each acknowledged
// R11: controller keeps pointer msb at zero
// R12: pointer advances after each acknowledged write byte
// R13: read: pointer write, repeated start, read address
// R14: controller acks all but last, then stops
// R15: pointer advances after each byte read out
// R16: receiver may hold clock low to stall
// R17: controller configures control registers after power-up
// R18: mismatch: no ack, ignore until next start
`timescale 1ns/1ns
`default_nettype none
module atp_i2c_target
  import atp_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = ATP_TARGET_ADDR,  // matched address
  parameter int         FIFO_DEPTH  = ATP_FIFO_DEPTH    // write buffer depth
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       en,         // clock enable, low freezes all state
  input  wire logic       scl_in,     // serial clock pin level
  output logic            scl_out,    // serial clock drive value, always low
  output logic            scl_oe,     // high while stretching the clock
  input  wire logic       sda_in,     // serial data pin level
  output logic            sda_out,    // serial data drive value, always low
  output logic            sda_oe,     // high while pulling data low
  output logic            bus_busy,   // between start and stop
  output logic            wr_valid,   // write word available
  input  wire logic       wr_ready,   // register file takes the word
  output logic [7:0]      wr_addr,    // register written
  output logic [7:0]      wr_data,    // byte written
  output logic            rd_req,     // one-cycle read request
  output logic [7:0]      rd_addr,    // register to read
  input  wire logic       rd_valid,   // one-cycle answer to rd_req
  input  wire logic [7:0] rd_data     // byte answered
);
  // refuse a buffer too small for the shifting FIFO
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("atp_i2c_target needs FIFO_DEPTH >= 2");
  end

  // pin synchronisers; stage 0 feeds only stage 1
  logic [ATP_SYNC_STAGES-1:0] scl_sync;
  logic [ATP_SYNC_STAGES-1:0] sda_sync;
  logic                       scl_prev;   // last synced clock level
  logic                       sda_prev;   // last synced data level
  logic                       scl_s;
  logic                       sda_s;
  logic                       scl_rise;
  logic                       scl_fall;
  logic                       start_det;
  logic                       stop_det;

  // sequencer state and its next values
  atp_state_t state;
  atp_state_t next_state;
  logic [7:0] shreg;           // byte being shifted in or out
  logic [7:0] next_shreg;
  logic [2:0] bit_cnt;         // bits done in this byte
  logic [2:0] next_bit_cnt;
  logic       byte_done;       // eighth bit sampled, decide at next fall
  logic       next_byte_done;
  logic       dir_read;        // current address byte asked for a read
  logic       next_dir_read;
  logic       ack_ok;          // controller acknowledged last read byte
  logic       next_ack_ok;
  logic [7:0] ptr;             // register_pointer
  logic [7:0] next_ptr;
  logic       next_scl_oe;
  logic       next_sda_oe;
  logic       next_bus_busy;
  logic       next_rd_req;
  logic [7:0] next_rd_addr;
  logic [7:0] rd_buf;          // fetched read byte
  logic [7:0] next_rd_buf;
  logic       rd_have;         // rd_buf holds an unused answer
  logic       next_rd_have;
  logic       ptr_pending;     // next received byte is the register_pointer
  logic       next_ptr_pending;

  // write buffer handshake
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic [15:0] fifo_in_data;
  logic [15:0] fifo_out_data;

  assign scl_s     = scl_sync[ATP_SYNC_STAGES-1];
  assign sda_s     = sda_sync[ATP_SYNC_STAGES-1];
  assign scl_rise  = scl_s & ~scl_prev;
  assign scl_fall  = ~scl_s & scl_prev;
  assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;  // R5
  assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;  // R9
  assign wr_addr   = fifo_out_data[15:8];
  assign wr_data   = fifo_out_data[7:0];

  // both pins pass two flops before any logic looks at them
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync <= '1;
      sda_sync <= '1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (en) begin
      scl_sync <= {scl_sync[ATP_SYNC_STAGES-2:0], scl_in};
      sda_sync <= {sda_sync[ATP_SYNC_STAGES-2:0], sda_in};
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // sequencer: sample on clock rise, change data on clock fall
  always_comb begin
    next_state     = state;
    next_shreg     = shreg;
    next_bit_cnt   = bit_cnt;
    next_byte_done = byte_done;
    next_dir_read  = dir_read;
    next_ack_ok    = ack_ok;
    next_ptr       = ptr;
    next_scl_oe    = scl_oe;
    next_sda_oe    = sda_oe;
    next_bus_busy  = bus_busy;
    next_rd_req    = 1'b0;
    next_rd_addr   = rd_addr;
    next_rd_buf    = rd_buf;
    next_rd_have   = rd_have;
    fifo_in_valid  = 1'b0;
    fifo_in_data   = {ptr, shreg};
    if (start_det) begin
      // start or repeated start; pointer survives for the read sequence
      next_state     = ATP_ADDR;                          // R13
      next_bus_busy  = 1'b1;                              // R5
      next_bit_cnt   = '0;
      next_byte_done = 1'b0;
      next_sda_oe    = 1'b0;
      next_scl_oe    = 1'b0;
    end else if (stop_det) begin
      next_state    = ATP_IDLE;                           // R9
      next_bus_busy = 1'b0;                               // R4
      next_sda_oe   = 1'b0;
      next_scl_oe   = 1'b0;
    end else begin
      case (state)
        ATP_ADDR, ATP_PTR, ATP_WDATA: begin
          if (scl_rise && !byte_done) begin
            next_shreg   = {shreg[6:0], sda_s};           // R3
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == 3'(ATP_BYTE_BITS - 1)) begin
              next_byte_done = 1'b1;
            end
          end else if (scl_fall && byte_done) begin
            next_byte_done = 1'b0;
            next_bit_cnt   = '0;
            if (state == ATP_ADDR) begin
              if (shreg[7:1] == TARGET_ADDR) begin        // R6 R7
                next_dir_read = (shreg[0] == ATP_DIR_READ);
                next_sda_oe   = 1'b1;                     // R8
                next_state    = ATP_ACK;
                if (shreg[0] == ATP_DIR_READ) begin
                  // fetch early so stretching is rare
                  next_rd_req  = 1'b1;
                  next_rd_addr = ptr;
                  next_rd_have = 1'b0;
                end
              end else begin
                next_state = ATP_IGNORE;                  // R18
              end
            end else if (state == ATP_PTR) begin
              next_ptr    = shreg;                        // R10
              next_sda_oe = 1'b1;                         // R8
              next_state  = ATP_ACK;
            end else begin
              next_state = ATP_PUSH;
            end
          end
        end
        ATP_PUSH: begin
          // clock stays low until the buffer has room
          if (fifo_in_ready) begin
            fifo_in_valid = 1'b1;                         // R10
            next_ptr      = ptr + 8'h01;                  // R12
            next_sda_oe   = 1'b1;                         // R8
            next_scl_oe   = 1'b0;
            next_state    = ATP_ACK;
          end else begin
            next_scl_oe = 1'b1;                           // R16
          end
        end
        ATP_ACK: begin
          // release data after the acknowledge bit
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            if (dir_read) begin
              next_state = ATP_LOAD;
            end else if (state == ATP_ACK && ptr_pending) begin
              next_state = ATP_PTR;
            end else begin
              next_state = ATP_WDATA;
            end
          end
        end
        ATP_LOAD: begin
          // clock held low until the read answer is in
          if (rd_have) begin
            next_shreg   = rd_buf;
            next_sda_oe  = ~rd_buf[7];                    // R3
            next_rd_have = 1'b0;
            next_bit_cnt = '0;
            next_scl_oe  = 1'b0;
            next_state   = ATP_TX;
          end else begin
            next_scl_oe = 1'b1;                           // R16
          end
        end
        ATP_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 3'(ATP_BYTE_BITS - 1)) begin
              next_sda_oe = 1'b0;                         // R8
              next_state  = ATP_RACK;
            end else begin
              next_shreg  = {shreg[6:0], 1'b0};
              next_sda_oe = ~shreg[6];
            end
            next_bit_cnt = bit_cnt + 3'h1;
          end
        end
        ATP_RACK: begin
          if (scl_rise) begin
            next_ptr    = ptr + 8'h01;                    // R15
            next_ack_ok = ~sda_s;
            if (!sda_s) begin
              next_rd_req  = 1'b1;
              next_rd_addr = ptr + 8'h01;
              next_rd_have = 1'b0;
            end
          end else if (scl_fall) begin
            // a not-acknowledge ends our part until stop or start
            next_state = ack_ok ? ATP_LOAD : ATP_IGNORE;  // R14
          end
        end
        ATP_IDLE, ATP_IGNORE: begin
          next_sda_oe = 1'b0;                             // R18
          next_scl_oe = 1'b0;
        end
        default: begin
          next_state = ATP_IDLE;
        end
      endcase
    end
    // answer capture last: a fresh answer wins over any clear above
    if (rd_valid) begin
      next_rd_buf  = rd_data;
      next_rd_have = 1'b1;
    end
  end

  // after a write address the next received byte is the pointer
  always_comb begin
    next_ptr_pending = ptr_pending;
    if (start_det) begin
      next_ptr_pending = 1'b1;
    end else if (state == ATP_ACK && scl_fall) begin
      next_ptr_pending = 1'b0;
    end
  end

  // sequencer registers; drive values of both pins stay low, open-drain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state       <= ATP_IDLE;
      shreg       <= '0;
      bit_cnt     <= '0;
      byte_done   <= 1'b0;
      dir_read    <= 1'b0;
      ack_ok      <= 1'b0;
      ptr         <= ATP_PTR_RESET;
      ptr_pending <= 1'b0;
      scl_oe      <= 1'b0;
      sda_oe      <= 1'b0;
      scl_out     <= 1'b0;                                // R1
      sda_out     <= 1'b0;
      bus_busy    <= 1'b0;
      rd_req      <= 1'b0;
      rd_addr     <= ATP_PTR_RESET;
      rd_buf      <= '0;
      rd_have     <= 1'b0;
    end else if (en) begin
      state       <= next_state;
      shreg       <= next_shreg;
      bit_cnt     <= next_bit_cnt;
      byte_done   <= next_byte_done;
      dir_read    <= next_dir_read;
      ack_ok      <= next_ack_ok;
      ptr         <= next_ptr;
      ptr_pending <= next_ptr_pending;
      scl_oe      <= next_scl_oe;
      sda_oe      <= next_sda_oe;
      scl_out     <= 1'b0;
      sda_out     <= 1'b0;
      bus_busy    <= next_bus_busy;
      rd_req      <= next_rd_req;
      rd_addr     <= next_rd_addr;
      rd_buf      <= next_rd_buf;
      rd_have     <= next_rd_have;
    end
  end

  // write words queue here so a slow register file stalls by clock stretching
  atp_fifo #(
    .WIDTH (ATP_FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .en        (en),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out_data)
  );
endmodule
`default_nettype wire

// ===== verif/atp_i2c_target_assertions.sv
// concurrent checks on the target port pins and register side
`timescale 1ns/1ns
`default_nettype none
module atp_chk
  import atp_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = ATP_TARGET_ADDR,  // matched address
  parameter int         FIFO_DEPTH  = ATP_FIFO_DEPTH    // write buffer depth
) (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       en,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       bus_busy,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic       rd_req,
  input wire logic [7:0] rd_addr,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data
);
  logic       sda_q;      // data pin one cycle back
  logic       have_rd;    // a fetch seen since the last start
  logic [7:0] last_rd;    // address of that fetch
  logic       next_have;  // next fetch flag
  logic [7:0] next_last;  // next fetch address
  // a start forgets the previous fetch, since the pointer may be rewritten
  always_comb begin
    next_have = have_rd;
    next_last = last_rd;
    if (scl_in && sda_q && !sda_in) begin
      next_have = 1'b0;
    end
    if (rd_req) begin
      next_have = 1'b1;
      next_last = rd_addr;
    end
  end
  // register helper state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_q   <= 1'b1;
      have_rd <= 1'b0;
      last_rd <= 8'h00;
    end else begin
      sda_q   <= sda_in;
      have_rd <= next_have;
      last_rd <= next_last;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !en);  // a frozen port answers nothing
  // bus conditions seen on the raw pins
  sequence start_s;
    scl_in && $fell(sda_in);
  endsequence
  sequence stop_s;
    scl_in && $rose(sda_in);
  endsequence
  drive_low_a: assert property (!scl_out && !sda_out)
    else $error("pin drive value not low");
  start_busy_a: assert property (start_s |-> ##[1:6] bus_busy)
    else $error("start not seen as busy");
  stop_idle_a: assert property (stop_s |-> ##[1:6] !bus_busy)
    else $error("stop not seen as idle");
  data_edge_a: assert property ($changed(sda_oe) |-> !$past(scl_in))
    else $error("data drive changed while clock high");
  drive_busy_a: assert property ((sda_oe || scl_oe) |-> bus_busy)
    else $error("pin driven outside a transfer");
  wr_hold_a: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
    else $error("write word dropped or changed");
  rd_pulse_a: assert property (rd_req |=> !rd_req)
    else $error("read request longer than a cycle");
  rd_incr_a: assert property (rd_req && have_rd |-> rd_addr == last_rd + 8'h01)
    else $error("read address did not advance by one");
endmodule
bind atp_i2c_target atp_chk #(.TARGET_ADDR(TARGET_ADDR), .FIFO_DEPTH(FIFO_DEPTH)) chk (
  .clk(clk), .nrst(nrst), .en(en), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .bus_busy(bus_busy),
  .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
  .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
`default_nettype wire

// ===== verif/atp_ctl_model.sv
// bus controller model: pulls clock and data low or releases them
`timescale 1ns/1ns
`default_nettype none
module atp_ctl_model (
  input  wire logic clk,
  input  wire logic scl,      // clock line level
  input  wire logic sda,      // data line level
  output var logic  scl_low,  // high pulls clock low
  output var logic  sda_low   // high pulls data low
);
  // both lines released: bus idle
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // wait whole bench clock cycles
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // release clock, wait out stretching, bounded
  task automatic rise();
    int i;
    scl_low = 1'b0;
    i = 0;
    while (!scl && i < 3000) begin
      tick(1);
      i++;
    end
    tick(3);
  endtask
  // one bit: data set mid-low, sampled at end of high
  task automatic bit_io(input logic b, output logic s);
    tick(2);
    sda_low = !b;
    tick(3);
    rise();
    s = sda;
    scl_low = 1'b1;
  endtask
  // start or repeated start
  task automatic start();
    if (scl_low) begin
      tick(2);
      sda_low = 1'b0;
      tick(3);
      rise();
    end
    sda_low = 1'b1;
    tick(3);
    scl_low = 1'b1;
  endtask
  // stop, leaves the bus idle
  task automatic stop();
    tick(2);
    sda_low = 1'b1;
    tick(3);
    rise();
    sda_low = 1'b0;
    tick(5);
  endtask
  // send a byte, return acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // take a byte, answer with ack or not
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, s);
  endtask
endmodule
`default_nettype wire

// ===== verif/accel_i2c_target_port_bench.sv
// self-checking bench of the two-wire target port
`timescale 1ns/1ns
`default_nettype none
module accel_i2c_target_port_bench;
  import atp_pkg::*;
  logic        clk, nrst, en, wr_ready, rd_valid, hold;
  logic        scl_low, sda_low, scl_out, scl_oe, sda_out, sda_oe;
  logic        bus_busy, wr_valid, rd_req;
  logic [7:0]  rd_data, wr_addr, wr_data, rd_addr;
  logic [7:0]  ref_mem [256];  // bench register file
  logic [15:0] exp_q[$];       // expected write words
  logic [31:0] seed = 32'h00012da7;
  int          n_fail, num_checks, cyc, stall_n, rd_wait;
  wire logic   scl_line;
  wire logic   sda_line;
  // pulled-up open-drain lines
  assign scl_line = !(scl_low || scl_oe);
  assign sda_line = !(sda_low || sda_oe);
  atp_i2c_target uut (.clk(clk), .nrst(nrst), .en(en), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .bus_busy(bus_busy), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
    .rd_data(rd_data));
  atp_ctl_model ctl (.clk(clk), .scl(scl_line), .sda(sda_line), .scl_low(scl_low),
    .sda_low(sda_low));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // pseudo-random byte from the shift register
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // write burst; expected words noted for the monitor
  task automatic wr_burst(input logic [7:0] p, input int n);
    logic       a;
    logic [7:0] d;
    ctl.start();
    ctl.wbyte({ATP_TARGET_ADDR, 1'b0}, a);
    check("addr ack", a, 1'b1);
    ctl.wbyte(p, a);
    check("ptr ack", a, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      exp_q.push_back({p + 8'(i), d});
      ref_mem[p + 8'(i)] = d;
      ctl.wbyte(d, a);
      check("data ack", a, 1'b1);
    end
    ctl.stop();
  endtask
  // read burst, optionally setting the pointer first
  task automatic rd_burst(input logic [7:0] p, input int n, input logic setp);
    logic       a;
    logic [7:0] b;
    ctl.start();
    if (setp) begin
      ctl.wbyte({ATP_TARGET_ADDR, 1'b0}, a);
      ctl.wbyte(p, a);
      ctl.start();
    end
    ctl.wbyte({ATP_TARGET_ADDR, ATP_DIR_READ}, a);
    check("read ack", a, 1'b1);
    for (int i = 0; i < n; i++) begin
      ctl.rbyte(i == n - 1, b);
      check("read data", b, ref_mem[p + 8'(i)]);
    end
    ctl.stop();
  endtask
  // register side: random write stalls, late read answers; one nonblocking assignment per output
  always @(negedge clk) begin
    if (scl_oe && hold) stall_n++;
    wr_ready <= !(hold && stall_n <= 50) && rnd() > 8'h50;
    rd_valid <= !rd_req && rd_wait == 1;
    if (rd_req) begin
      rd_wait = rnd() % 12 + 1;
    end else if (rd_wait > 0) begin
      rd_wait--;
      if (rd_wait == 0) begin
        rd_data <= ref_mem[rd_addr];
      end
    end
  end
  // monitor: each popped word against the oldest note
  always @(posedge clk) begin
    if (nrst && en && wr_valid && wr_ready) begin
      if (exp_q.size() == 0) check("extra word", 1'b1, 1'b0);
      else check("write word", {wr_addr, wr_data}, exp_q.pop_front());
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    logic a;
    nrst = 1'b0;
    en = 1'b1;
    hold = 1'b0;
    for (int i = 0; i < 256; i++) ref_mem[i] = rnd();
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    check("busy", bus_busy, 1'b0);
    repeat (4) @(negedge clk);
    wr_burst(8'h10, 1);
    wr_burst(rnd() & 8'h7f, 3);
    hold = 1'b1;
    wr_burst(8'h7c, 7);
    rd_burst(8'h7c, 4, 1'b1);
    rd_burst(8'h80, 2, 1'b0);
    // every single-bit address miss: no ack, rest ignored
    for (int i = 0; i < 7; i++) begin
      ctl.start();
      ctl.wbyte({ATP_TARGET_ADDR ^ (7'h01 << i), 1'b0}, a);
      check("miss nack", a, 1'b0);
      check("busy", bus_busy, 1'b1);
      ctl.wbyte({ATP_TARGET_ADDR, 1'b0}, a);
      check("ignored", a, 1'b0);
      ctl.stop();
      check("idle", bus_busy, 1'b0);
    end
    // enable low freezes the port: a matching address goes unanswered
    en = 1'b0;
    ctl.start();
    ctl.wbyte({ATP_TARGET_ADDR, 1'b0}, a);
    ctl.stop();
    en = 1'b1;
    check("frozen nack", a, 1'b0);
    repeat (4) @(negedge clk);
    check("frozen idle", bus_busy, 1'b0);
    for (int i = 0; i < 800 && exp_q.size() > 0; i++) @(negedge clk);
    check("drained", 16'(exp_q.size()), 16'h0000);
    check("stretched", stall_n > 0, 1'b1);
    test_done();
  end
endmodule
`default_nettype wire
